// [src/bcfb_pkg.sv]
package bcfb_pkg;

  // widths of the datapath
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned DADDR_W = 12;
  localparam int unsigned PC_W    = 21;
  localparam int unsigned BANK_W  = 4;

  // instruction encodings
  localparam logic [3:0] BIT_CLEAR_PREFIX   = 4'h9;
  localparam logic [7:0] BR_NEG_PREFIX      = 8'hE6;
  localparam logic [7:0] BR_NO_CARRY_PREFIX = 8'hE3;

  // operand field positions
  localparam int unsigned BIT_SEL_LSB = 9;
  localparam int unsigned BANK_BIT    = 8;

  // access bank split and indexed literal offset limit
  localparam logic [7:0]         ACCESS_SPLIT = 8'h80;
  localparam logic [7:0]         ILO_LIMIT    = 8'h5F;
  localparam logic [DADDR_W-1:0] ACCESS_HI    = 12'hF00;
  localparam logic [DADDR_W-1:0] ACCESS_LO    = 12'h000;

  // q phase numbers inside one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // value after reset of registers
  localparam logic [DADDR_W-1:0] ADDR_RST   = 12'h000;
  localparam logic [PC_W-1:0]    TARGET_RST = 21'h00_0000;

  // operation being executed
  typedef enum logic [2:0] {
    OP_NONE,
    OP_BIT_CLEAR,
    OP_BR_NEG,
    OP_BR_NO_CARRY,
    OP_FLUSH
  } bcfb_op_t;

  // whole state of the executer
  typedef struct packed {
    logic [1:0]         phase;
    bcfb_op_t           op;
    logic [2:0]         bit_sel;
    logic [DADDR_W-1:0] addr;
    logic [7:0]         data;
    logic [7:0]         offs;
    logic               taken;
    logic [PC_W-1:0]    target;
    logic               flush_pend;
  } bcfb_state_t;

endpackage

// [src/bcfb_exec.sv]
`timescale 1ns/1ns
// Operation
// RULE1 - bit clear forces bit b of the addressed file register to zero, keeping the other bits.
// RULE2 - with bank bit zero the address is resolved inside the fixed access bank.
// RULE3 - with bank bit one the upper address bits come from the bank select register.
// RULE4 - with extended set on, bank bit zero and address up to 95 the operand is an indexed literal offset.
// RULE5 - a taken branch goes to the incremented program counter plus twice the sign-extended offset.
// RULE6 - branch on negative is taken only when the negative flag is one.
// RULE7 - branch on no carry is taken only when the carry flag is zero.
// RULE8 - a branch takes one cycle when not taken and two when taken, the second one flushing.
// RULE9 - each branch is one word, so falling through means the next sequential word.
// RULE10 - none of these instructions changes any arithmetic status flag.
// RULE11 - decode in q1, read in q2, process in q3, write register or program counter in q4.
module bcfb_exec (
  // clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         sys_rst_i,
  // instruction from fetch, sampled in q1
  input  wire logic [bcfb_pkg::INSTR_W-1:0] instr_i,
  input  wire logic                         instr_valid_i,
  // core state
  input  wire logic [bcfb_pkg::PC_W-1:0]    pc_i,
  input  wire logic                         flag_neg_i,
  input  wire logic                         flag_carry_i,
  input  wire logic                         ext_set_en_i,
  input  wire logic [bcfb_pkg::BANK_W-1:0]  bank_select_register_i,
  input  wire logic [bcfb_pkg::DADDR_W-1:0] index_base_i,
  // data memory
  output logic      [bcfb_pkg::DADDR_W-1:0] mem_addr_o,
  output logic                              mem_rd_o,
  input  wire logic [7:0]                   mem_rdata_i,
  output logic                              mem_wr_o,
  output logic      [7:0]                   mem_wdata_o,
  // program counter
  output logic                              pc_load_o,
  output logic      [bcfb_pkg::PC_W-1:0]    pc_target_o,
  // pipeline and status
  output logic                              flush_o,
  output logic      [1:0]                   q_phase_o,
  output logic                              status_we_o
);

  bcfb_pkg::bcfb_state_t st_reg;
  bcfb_pkg::bcfb_state_t st_next;

  // decode helpers for the instruction word
  logic                         is_bit_clear;
  logic                         is_br_neg;
  logic                         is_br_no_carry;
  logic                         is_branch;
  logic [2:0]                   bit_field;
  logic [7:0]                   f_addr;
  logic                         bank_bit;

  // candidate addresses of the three addressing modes
  logic [bcfb_pkg::DADDR_W-1:0] banked_addr;
  logic [bcfb_pkg::DADDR_W-1:0] indexed_addr;
  logic [bcfb_pkg::DADDR_W-1:0] access_addr;
  logic                         use_indexed;
  logic [bcfb_pkg::DADDR_W-1:0] res_addr;

  // phase decode of the running instruction cycle
  logic                         in_q1;
  logic                         in_q2;
  logic                         in_q4;

  // branch condition and arithmetic
  logic                         take_on_neg;
  logic                         take_on_no_carry;
  logic                         cond_ok;
  logic                         op_is_branch;
  logic [bcfb_pkg::PC_W-1:0]    offs_ext;
  logic [bcfb_pkg::PC_W-1:0]    br_target;

  // bit clear datapath
  logic [7:0]                   clr_mask;
  logic [7:0]                   cleared_data;

  // opcode prefixes and operand fields of the fetched word
  assign is_bit_clear   = (instr_i[15:12] == bcfb_pkg::BIT_CLEAR_PREFIX);   // [RULE1]
  assign is_br_neg      = (instr_i[15:8] == bcfb_pkg::BR_NEG_PREFIX);       // [RULE6]
  assign is_br_no_carry = (instr_i[15:8] == bcfb_pkg::BR_NO_CARRY_PREFIX);  // [RULE7]
  assign is_branch      = is_br_neg || is_br_no_carry;
  assign bit_field      = instr_i[bcfb_pkg::BIT_SEL_LSB +: 3];
  assign f_addr         = instr_i[7:0];
  assign bank_bit       = instr_i[bcfb_pkg::BANK_BIT];

  // bank select register supplies the upper address bits
  assign banked_addr  = {bank_select_register_i, f_addr};                   // [RULE3]
  // index base plus literal offset, wraps at the top of data memory
  assign indexed_addr = index_base_i + {4'h0, f_addr};                      // [RULE4]
  assign use_indexed  = ext_set_en_i && (f_addr <= bcfb_pkg::ILO_LIMIT);    // [RULE4]
  // lower half of the access bank is low memory, upper half the top page
  assign access_addr  = (f_addr >= bcfb_pkg::ACCESS_SPLIT) ? (bcfb_pkg::ACCESS_HI | {4'h0, f_addr})
                                                          : (bcfb_pkg::ACCESS_LO | {4'h0, f_addr}); // [RULE2]

  // file address resolution, bank bit first, then indexed, then access bank
  always_comb begin
    if (bank_bit) begin
      res_addr = banked_addr;                                               // [RULE3]
    end else if (use_indexed) begin
      res_addr = indexed_addr;                                              // [RULE4]
    end else begin
      res_addr = access_addr;                                               // [RULE2]
    end
  end

  // phase strobes from the phase counter
  assign in_q1 = (st_reg.phase == bcfb_pkg::PH_Q1);
  assign in_q2 = (st_reg.phase == bcfb_pkg::PH_Q2);
  assign in_q4 = (st_reg.phase == bcfb_pkg::PH_Q4);

  // flag tests of the two branches
  assign take_on_neg      = flag_neg_i;                                     // [RULE6]
  assign take_on_no_carry = !flag_carry_i;                                  // [RULE7]

  // branch condition per operation
  always_comb begin
    case (st_reg.op)
      bcfb_pkg::OP_BR_NEG:      cond_ok = take_on_neg;                      // [RULE6]
      bcfb_pkg::OP_BR_NO_CARRY: cond_ok = take_on_no_carry;                 // [RULE7]
      default:                  cond_ok = 1'b0;
    endcase
  end

  // offset doubled and sign extended to counter width, added to the incremented counter
  assign op_is_branch = (st_reg.op == bcfb_pkg::OP_BR_NEG) || (st_reg.op == bcfb_pkg::OP_BR_NO_CARRY);
  assign offs_ext     = {{12{st_reg.offs[7]}}, st_reg.offs, 1'b0};          // [RULE5]
  assign br_target    = pc_i + offs_ext;                                    // [RULE5]

  // one-hot mask of the bit to clear, one lane per data bit
  for (genvar gi = 0; gi < 8; gi++) begin : g_clr_mask
    assign clr_mask[gi] = (st_reg.bit_sel == 3'(gi));                       // [RULE1]
  end

  // other bits pass unchanged
  assign cleared_data = st_reg.data & ~clr_mask;                            // [RULE1]

  // next state: four q phases per instruction cycle
  always_comb begin
    st_next       = st_reg;
    st_next.phase = st_reg.phase + 2'h1;
    case (st_reg.phase)
      bcfb_pkg::PH_Q1: begin
        // decode; a new word is only looked at outside the flush cycle
        st_next.taken = 1'b0;
        if (st_reg.flush_pend) begin
          // idle cycle after a taken branch, fetched word is dropped
          st_next.op         = bcfb_pkg::OP_FLUSH;                       // [RULE8]
          st_next.flush_pend = 1'b0;
        end else if (instr_valid_i && is_bit_clear) begin
          st_next.op      = bcfb_pkg::OP_BIT_CLEAR;                       // [RULE11]
          st_next.bit_sel = bit_field;
          st_next.addr    = res_addr;
        end else if (instr_valid_i && is_branch) begin
          st_next.op   = is_br_neg ? bcfb_pkg::OP_BR_NEG : bcfb_pkg::OP_BR_NO_CARRY;
          st_next.offs = instr_i[7:0];                                    // [RULE11]
        end else begin
          // unknown or absent word runs as an empty cycle
          st_next.op = bcfb_pkg::OP_NONE;
        end
      end
      bcfb_pkg::PH_Q2: begin
        // read the register while the read strobe stands
        if (st_reg.op == bcfb_pkg::OP_BIT_CLEAR) begin
          st_next.data = mem_rdata_i;                                     // [RULE11]
        end
      end
      bcfb_pkg::PH_Q3: begin
        if (st_reg.op == bcfb_pkg::OP_BIT_CLEAR) begin
          st_next.data = cleared_data;                                    // [RULE1]
        end else if (op_is_branch) begin
          // pc_i already points at the next word, so untaken falls through
          st_next.taken  = cond_ok;                                       // [RULE9]
          st_next.target = br_target;                                     // [RULE5]
        end
      end
      default: begin
        // q4: write back or load the counter, and arm the flush
        if (st_reg.taken) begin
          st_next.flush_pend = 1'b1;                                      // [RULE8]
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_reg.phase      <= bcfb_pkg::PH_Q1;
      st_reg.op         <= bcfb_pkg::OP_NONE;
      st_reg.bit_sel    <= 3'h0;
      st_reg.addr       <= bcfb_pkg::ADDR_RST;
      st_reg.data       <= 8'h00;
      st_reg.offs       <= 8'h00;
      st_reg.taken      <= 1'b0;
      st_reg.target     <= bcfb_pkg::TARGET_RST;
      st_reg.flush_pend <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // read strobe for the whole q2 of a bit clear
  assign mem_rd_o    = (st_reg.op == bcfb_pkg::OP_BIT_CLEAR) && in_q2;                           // [RULE11]

  // write strobe for the whole q4 of a bit clear
  assign mem_wr_o    = (st_reg.op == bcfb_pkg::OP_BIT_CLEAR) && in_q4;                           // [RULE11]

  // counter load in q4 of a taken branch
  assign pc_load_o   = st_reg.taken && in_q4;                                                    // [RULE11]

  // flush covers q1 to q4 of the idle cycle; in its q1 the op still names the branch
  assign flush_o     = (st_reg.flush_pend && in_q1) || ((st_reg.op == bcfb_pkg::OP_FLUSH) && !in_q1); // [RULE8]

  // phase and flag write enable
  assign q_phase_o   = st_reg.phase;
  assign status_we_o = 1'b0;                                   // flags never written [RULE10]

  // data outputs straight from the state flops
  assign mem_addr_o  = st_reg.addr;
  assign mem_wdata_o = st_reg.data;
  assign pc_target_o = st_reg.target;

endmodule

// [verif/bcfb_chk.sv]
`timescale 1ns/1ns
module bcfb_chk (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  // watched inputs
  input wire logic        instr_valid_i,
  input wire logic        flag_neg_i,
  input wire logic        flag_carry_i,
  input wire logic [15:0] instr_i,
  // watched outputs
  input wire logic [1:0]  q_phase_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic        pc_load_o,
  input wire logic        flush_o,
  input wire logic        status_we_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // branch accepted in q1, then run on to its q3
  sequence br_s(logic [7:0] p);
    q_phase_o == 2'h0 && instr_valid_i && !flush_o && instr_i[15:8] == p ##2 1'b1;
  endsequence
  // bit clear accepted in q1
  sequence clr_s;
    q_phase_o == 2'h0 && instr_valid_i && !flush_o && instr_i[15:12] == 4'h9;
  endsequence
  phase_step_a: assert property (!$past(sys_rst_i) |-> q_phase_o == $past(q_phase_o) + 2'h1)
    else $error("phase did not advance");
  clr_strobes_a: assert property (clr_s |=> mem_rd_o ##2 mem_wr_o)
    else $error("bit clear strobes missing");
  rd_phase_a: assert property (mem_rd_o |-> q_phase_o == 2'h1)
    else $error("read outside q2");
  wr_after_rd_a: assert property (mem_wr_o |-> $past(mem_rd_o, 2) && q_phase_o == 2'h3)
    else $error("write without read");
  neg_branch_a: assert property (br_s(8'hE6) |=> pc_load_o == $past(flag_neg_i))
    else $error("negative branch wrong");
  nc_branch_a: assert property (br_s(8'hE3) |=> pc_load_o == !$past(flag_carry_i))
    else $error("no carry branch wrong");
  load_flush_a: assert property (pc_load_o |-> q_phase_o == 2'h3 ##1 flush_o [*4] ##1 !flush_o)
    else $error("flush cycle wrong");
  flush_quiet_a: assert property (flush_o |-> !mem_rd_o && !mem_wr_o && !pc_load_o)
    else $error("activity in flush");
  no_flags_a: assert property (!status_we_o)
    else $error("flag write seen");
endmodule
bind bcfb_exec bcfb_chk u_chk (.clk_sys_i, .sys_rst_i, .instr_valid_i, .flag_neg_i, .flag_carry_i,
  .instr_i, .q_phase_o, .mem_rd_o, .mem_wr_o, .pc_load_o, .flush_o, .status_we_o);

// [verif/bcfb_mem.sv]
`timescale 1ns/1ns
module bcfb_mem (
  input  wire logic        clk_sys_i,
  input  wire logic [11:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o
);
  logic [7:0] ram [4096];
  // start contents: low address byte xor upper eight address bits
  initial for (int i = 0; i < 4096; i++) ram[i] = i[7:0] ^ i[11:4];
  // data only while read strobe is up, inverted junk otherwise
  assign mem_rdata_o = mem_rd_i ? ram[mem_addr_i] : ~ram[mem_addr_i];
  // write back on the write strobe
  always @(posedge clk_sys_i) if (mem_wr_i) ram[mem_addr_i] <= mem_wdata_i;
endmodule

// [verif/bcfb_exec_tb.sv]
`timescale 1ns/1ns
module bcfb_exec_tb;
  logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1, instr_valid_i = 1'b0, flag_neg_i = 1'b0;
  logic        flag_carry_i = 1'b0, ext_set_en_i = 1'b0, mem_rd_o, mem_wr_o, pc_load_o, flush_o, status_we_o;
  logic [15:0] instr_i = 16'h0000;
  logic [15:0] corner [7] = '{16'h9E5F, 16'h9C60, 16'h9080, 16'h9F00, 16'hE680, 16'hE37F, 16'h0000};
  logic [20:0] pc_i = 21'h00_0000, pc_target_o;
  logic [11:0] index_base_i = 12'h000, mem_addr_o;
  logic [3:0]  bank_select_register_i = 4'h0;
  logic [7:0]  mem_rdata_i, mem_wdata_o;
  logic [1:0]  q_phase_o;
  logic [31:0] seed = 32'he51d_a1e1;
  int          n_fail = 0, n_tests = 0, cyc = 0;
  // executer and its data memory
  bcfb_exec dut (.clk_sys_i, .sys_rst_i, .instr_i, .instr_valid_i, .pc_i, .flag_neg_i, .flag_carry_i,
    .ext_set_en_i, .bank_select_register_i, .index_base_i, .mem_addr_o, .mem_rd_o, .mem_rdata_i,
    .mem_wr_o, .mem_wdata_o, .pc_load_o, .pc_target_o, .flush_o, .q_phase_o, .status_we_o);
  bcfb_mem u_mem (.clk_sys_i, .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;
  // hang guard, far above the expected run
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected data address of a bit clear
  function automatic logic [11:0] exp_addr(logic [15:0] w, logic [3:0] b, logic e, logic [11:0] x);
    if (w[8]) return {b, w[7:0]};
    if (e && w[7:0] <= 8'h5F) return x + {4'h0, w[7:0]};
    return {{4{w[7]}}, w[7:0]};
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // issue one word in q1 with random core state, junk in later phases
  task automatic op(logic [15:0] w, logic v);
    logic [31:0] r;
    logic [7:0]  d;
    logic        clr, tk;
    r = rnd();
    clr = v && w[15:12] == 4'h9;
    tk = v && (w[15:8] == 8'hE6 && r[5] || w[15:8] == 8'hE3 && !r[6]);
    do @(negedge clk_sys_i); while (q_phase_o !== 2'h3 || pc_load_o !== 1'b0);
    d = u_mem.ram[exp_addr(w, r[3:0], r[4], r[18:7])] & ~(8'h01 << w[11:9]);
    @(posedge clk_sys_i);
    instr_i <= w;
    instr_valid_i <= v;
    bank_select_register_i <= r[3:0];
    ext_set_en_i <= r[4];
    flag_neg_i <= r[5];
    flag_carry_i <= r[6];
    index_base_i <= r[18:7];
    pc_i <= {r[31:12], 1'b0};
    @(posedge clk_sys_i);
    instr_i <= r[15:0];
    instr_valid_i <= r[16] && tk;
    @(negedge clk_sys_i);
    chk(mem_rd_o, clr);
    if (clr) chk(mem_addr_o, exp_addr(w, r[3:0], r[4], r[18:7]));
    repeat (2) @(negedge clk_sys_i);
    chk(mem_wr_o, clr);
    if (clr) chk(mem_wdata_o, d);
    chk(pc_load_o, tk);
    if (tk) chk(pc_target_o, 21'({r[31:12], 1'b0} + {{12{w[7]}}, w[7:0], 1'b0}));
    @(negedge clk_sys_i);
    chk(flush_o, tk);
    chk(status_we_o, 1'b0);
  endtask
  // reset, corner words, then random words
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    foreach (corner[i]) op(corner[i], 1'b1);
    for (int i = 0; i < 80; i++) begin
      r = rnd();
      case (r[1:0])
        2'h1: w = {4'h9, r[27:16]};
        2'h2: w = {8'hE6, r[23:16]};
        2'h3: w = {8'hE3, r[23:16]};
        default: w = {4'h0, r[27:16]};
      endcase
      op(w, r[31:30] != 2'h0);
    end
    end_sim();
  end
endmodule
